/* File: rtl/csd_defs.svh */
// Register map, field positions, reset values, limit codes and timing figures
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define CSD_A_CTRL 8'h00
`define CSD_A_CURRENT_LIMIT_PIN 8'h01
`define CSD_A_VLIM 8'h02
`define CSD_A_BST 8'h03
`define CSD_A_CHG 8'h04
`define CSD_A_STAT 8'h05
`define CSD_A_OPT 8'h06
`define CSD_A_EFF 8'h07
// ****************************************
// Control bits and boost fields
// ****************************************
`define CSD_B_AUTO 0
`define CSD_B_HVA 1
`define CSD_B_HVB 2
`define CSD_B_FDET 3
`define CSD_B_ABS 4
`define CSD_B_OPTEN 5
`define CSD_B_FOPT 6
`define CSD_B_PINEN 7
`define CSD_B_CFG 0
`define CSD_B_FREQ 1
`define CSD_B_BPFM 2
`define CSD_BV_HI 6
`define CSD_BV_LO 3
// ****************************************
// Reset values
// ****************************************
`define CSD_CTRL_RST 8'hA1
`define CSD_CURRENT_LIMIT_PIN_RST 7'h0A
`define CSD_VLIM_RST 8'h24
`define CSD_BST_RST 8'h30
`define CSD_VLIM_OS 8'h06
// ****************************************
// Current limit codes, 50 mA per step
// ****************************************
`define CSD_I_SDP 7'h0A
`define CSD_I_CDP 7'h1E
`define CSD_I_DCP 7'h41
`define CSD_I_DIV1 7'h2A
`define CSD_I_DIV2 7'h28
`define CSD_I_DIV3 7'h14
`define CSD_I_DIV4 7'h30
`define CSD_I_HV 7'h1E
`define CSD_I_UNK 7'h0A
`define CSD_I_SOFT 7'h04
// ****************************************
// Timing
// ****************************************
`define CSD_CLK_MHZ 250
`define CSD_DCD_MS 500
`define CSD_BST_MS 30
`define CSD_HV_MS 100
`define CSD_OPT_US 10
`endif

/* File: rtl/csd_pkg.sv */
// Types shared by the source detect and boost control block
package csd_pkg;
	typedef enum logic [2:0] {SRC_NONE = 3'h0, SRC_SDP = 3'h1, SRC_CDP = 3'h2, SRC_DCP = 3'h3,
		SRC_HV = 3'h4, SRC_UNK = 3'h5, SRC_DIV = 3'h6, SRC_BOOST = 3'h7} csd_src_t;
	typedef enum logic [1:0] {PORT_NONE = 2'h0, PORT_SDP = 2'h1, PORT_CDP = 2'h2, PORT_DCP = 2'h3} csd_port_t;
	typedef enum logic [1:0] {WIN_NONE = 2'h0, WIN_1P2 = 2'h1, WIN_2P0 = 2'h2, WIN_2P7 = 2'h3} csd_win_t;
	typedef enum logic [2:0] {S_IDLE, S_DCD, S_CLS, S_NSTD, S_HV, S_VSET, S_RUN} csd_st_t;
	typedef struct packed {
		logic       attach;
		logic       contact;
		csd_port_t  port;
		csd_win_t   dp_win;
		csd_win_t   dm_win;
		logic       sys_ok;
		logic       bat_min_ok;
		logic       bat_bst_ok;
		logic       vbus_low;
		logic       boost_req;
		logic       ts_ok;
		logic       vsag;
		logic [6:0] current_limit_pin_pin;
		logic [7:0] vbus_meas;
	} csd_pins_t;
	typedef struct packed {
		logic dp_src;
		logic dp_sink;
		logic dm_src;
		logic dm_sink;
	} csd_lines_t;
	typedef struct packed {
		csd_pins_t  s1;
		csd_pins_t  s2;
		csd_pins_t  s3;
		csd_pins_t  filt;
		logic [7:0] ctrl;
		logic [6:0] current_limit_pin;
		logic [7:0] vlim;
		logic [7:0] bst;
		logic       chg;
		csd_src_t   src;
		logic       std_stat;
		logic [6:0] opt_res;
		logic       opt_run;
		logic [31:0] ocnt;
		logic [6:0] eff;
		csd_st_t    st;
		logic [31:0] cnt;
		logic [31:0] bcnt;
		logic       bst_on;
		logic       conv;
		logic       bsw;
		logic       pfm;
		csd_lines_t lines;
		logic       intp;
		logic [7:0] rd;
	} csd_state_t;
endpackage

/* File: rtl/csd_ctrl.sv */
// Source detection, input limit, optimizer and boost qualification logic
//
// Operation
// - On attach, run port detection telling standard, charging and dedicated ports apart.
// - If contact is not seen within 500 ms, classify as non-standard adapter.
// - Four divider types by D+/D- windows give 2.1 A, 2 A, 1 A, 2.4 A.
// - After a dedicated port, run the high-voltage handshake asking for 9 V or 12 V.
// - Handshake is off by default and runs only when its enable bits are set.
// - 12 V: sink on D+, source on D-. 9 V: source on D+, sink on D-.
// - Detection end pulses interrupt and updates limit register and source-type fields.
// - Result codes and limits per source type as in the result table.
// - Force-detect bit reruns detection and clears itself when detection finishes.
// - Absolute select set disables the threshold algorithm; threshold becomes host-writable.
// - Absolute select clear by default; algorithm owns threshold, host writes ignored.
// - Setting the voltage threshold pulses the interrupt.
// - Converter starts after limit is set; battery switch off only when charging disabled.
// - System rail below 2.2 V limits input current to min of 200 mA and register.
// - Above 2.2 V, limit is register or optimizer result, clamped to min with pin only when pin enable is set.
// - Buck uses light-load pulse mode when battery below minimum or charging disabled.
// - Optimizer enable resets to 1; clearing it disables the optimizer.
// - Optimizer runs after dedicated or high-voltage source, or when forced.
// - Applied limit is optimizer result when enabled, else register; pin clamps if enabled.
// - Boost starts only with all conditions true for 30 ms.
// - During boost source type reads 111; boost voltage field defaults to 5.126 V code.
// - Detection runs only when auto-detect or force-detect is set; otherwise results are kept.
`timescale 1ns/100ps
`include "csd_defs.svh"
module csd_ctrl #(
	parameter int unsigned DCD_CYC = `CSD_DCD_MS * `CSD_CLK_MHZ * 1000,
	parameter int unsigned BST_CYC = `CSD_BST_MS * `CSD_CLK_MHZ * 1000,
	parameter int unsigned HV_CYC  = `CSD_HV_MS * `CSD_CLK_MHZ * 1000,
	parameter int unsigned OPT_CYC = `CSD_OPT_US * `CSD_CLK_MHZ
) (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic [7:0]         addr_in,
	input  wire logic [7:0]         wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	input  wire csd_pkg::csd_pins_t pins_in,
	output logic [7:0]              rd_data_out,
	output logic                    int_out,
	output logic                    conv_en_out,
	output logic                    battery_switch_out,
	output logic                    buck_pfm_out,
	output logic [6:0]              eff_limit_out,
	output logic [7:0]              vlimit_out,
	output csd_pkg::csd_lines_t     lines_out,
	output logic                    boost_en_out,
	output logic                    select_a_out,
	output logic                    boost_pfm_dis_out,
	output logic [3:0]              boost_volt_out
);
	csd_pkg::csd_state_t r;
	csd_pkg::csd_state_t n;

	function automatic logic [6:0] min7(input logic [6:0] a, input logic [6:0] b);
		min7 = (a < b) ? a : b;
	endfunction

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic            done;
		csd_pkg::csd_src_t res;
		logic [6:0]      res_i;
		logic [6:0]      lim_src;
		csd_pkg::csd_pins_t f;
		done = 1'b0;
		res = csd_pkg::SRC_UNK;
		res_i = `CSD_I_UNK;
		lim_src = 7'h00;
		f = r.filt;
		n = r;
		n.intp = 1'b0;
		n.rd = 8'h00;
		// Three stage sync; a change is accepted when stages two and three agree
		n.s1 = pins_in;
		n.s2 = r.s1;
		n.s3 = r.s2;
		if (r.s2 == r.s3)
		begin
			n.filt = r.s3;
		end
		unique case (r.st)
			csd_pkg::S_IDLE:
			begin
				if (f.attach)
				begin
					n.cnt = 32'h0000_0000;
					n.lines = '0;
					n.st = (r.ctrl[`CSD_B_AUTO] || r.ctrl[`CSD_B_FDET]) ? csd_pkg::S_DCD
						: csd_pkg::S_VSET;
				end
			end
			csd_pkg::S_DCD:
			begin
				n.cnt = r.cnt + 32'h0000_0001;
				if (f.contact)
				begin
					n.st = csd_pkg::S_CLS;
				end
				else if (r.cnt >= DCD_CYC - 1)
				begin
					n.st = csd_pkg::S_NSTD;
				end
			end
			csd_pkg::S_CLS:
			begin
				unique case (f.port)
					csd_pkg::PORT_SDP:
					begin
						done = 1'b1;
						res = csd_pkg::SRC_SDP;
						res_i = `CSD_I_SDP;
					end
					csd_pkg::PORT_CDP:
					begin
						done = 1'b1;
						res = csd_pkg::SRC_CDP;
						res_i = `CSD_I_CDP;
					end
					csd_pkg::PORT_DCP:
					begin
						if (r.ctrl[`CSD_B_HVA] || r.ctrl[`CSD_B_HVB])
						begin
							n.st = csd_pkg::S_HV;
							n.cnt = 32'h0000_0000;
							n.lines.dp_sink = r.ctrl[`CSD_B_HVA];
							n.lines.dm_src = r.ctrl[`CSD_B_HVA];
							n.lines.dp_src = !r.ctrl[`CSD_B_HVA];
							n.lines.dm_sink = !r.ctrl[`CSD_B_HVA];
						end
						else
						begin
							done = 1'b1;
							res = csd_pkg::SRC_DCP;
							res_i = `CSD_I_DCP;
						end
					end
					csd_pkg::PORT_NONE:
					begin
						done = 1'b1;
					end
				endcase
			end
			csd_pkg::S_NSTD:
			begin
				done = 1'b1;
				// Divider windows; anything else stays unknown
				case ({f.dp_win, f.dm_win})
					{csd_pkg::WIN_2P7, csd_pkg::WIN_2P0}: res_i = `CSD_I_DIV1;
					{csd_pkg::WIN_1P2, csd_pkg::WIN_1P2}: res_i = `CSD_I_DIV2;
					{csd_pkg::WIN_2P0, csd_pkg::WIN_2P7}: res_i = `CSD_I_DIV3;
					{csd_pkg::WIN_2P7, csd_pkg::WIN_2P7}: res_i = `CSD_I_DIV4;
					default: res_i = `CSD_I_UNK;
				endcase
				res = (res_i == `CSD_I_UNK) ? csd_pkg::SRC_UNK : csd_pkg::SRC_DIV;
			end
			csd_pkg::S_HV:
			begin
				// Lines stay driven so the adapter keeps the raised voltage
				n.cnt = r.cnt + 32'h0000_0001;
				if (r.cnt >= HV_CYC - 1)
				begin
					done = 1'b1;
					res = csd_pkg::SRC_HV;
					res_i = `CSD_I_HV;
				end
			end
			csd_pkg::S_VSET:
			begin
				if (!r.ctrl[`CSD_B_ABS])
				begin
					n.vlim = f.vbus_meas - `CSD_VLIM_OS;
				end
				n.intp = 1'b1;
				n.conv = 1'b1;
				n.st = csd_pkg::S_RUN;
			end
			csd_pkg::S_RUN:
			begin
				if (r.ctrl[`CSD_B_FDET])
				begin
					n.st = csd_pkg::S_DCD;
					n.cnt = 32'h0000_0000;
					n.lines = '0;
				end
			end
		endcase
		if (done)
		begin
			n.current_limit_pin = res_i;
			n.src = res;
			n.std_stat = (res == csd_pkg::SRC_SDP);
			n.intp = 1'b1;
			n.ctrl[`CSD_B_FDET] = 1'b0;
			n.st = csd_pkg::S_VSET;
			if (r.ctrl[`CSD_B_OPTEN] && (res == csd_pkg::SRC_DCP || res == csd_pkg::SRC_HV))
			begin
				n.opt_run = 1'b1;
				n.opt_res = `CSD_I_SOFT;
				n.ocnt = 32'h0000_0000;
			end
		end
		// ****************************************
		// Input current optimizer
		// ****************************************
		if (r.ctrl[`CSD_B_FOPT] && r.ctrl[`CSD_B_OPTEN])
		begin
			n.ctrl[`CSD_B_FOPT] = 1'b0;
			n.opt_run = 1'b1;
			n.opt_res = `CSD_I_SOFT;
			n.ocnt = 32'h0000_0000;
		end
		else if (r.opt_run)
		begin
			n.ocnt = r.ocnt + 32'h0000_0001;
			if (!r.ctrl[`CSD_B_OPTEN])
			begin
				n.opt_run = 1'b0;
			end
			else if (r.ocnt >= OPT_CYC - 1)
			begin
				n.ocnt = 32'h0000_0000;
				// Stop short of the point where the bus sags
				if (f.vsag)
				begin
					n.opt_run = 1'b0;
					n.opt_res = (r.opt_res > `CSD_I_SOFT) ? r.opt_res - 7'h01 : r.opt_res;
				end
				else if (r.opt_res >= r.current_limit_pin)
				begin
					n.opt_run = 1'b0;
				end
				else
				begin
					n.opt_res = r.opt_res + 7'h01;
				end
			end
		end
		if (!f.attach)
		begin
			n.st = csd_pkg::S_IDLE;
			n.conv = 1'b0;
			n.lines = '0;
			n.opt_run = 1'b0;
		end
		// ****************************************
		// Effective limit and converter outputs
		// ****************************************
		lim_src = r.ctrl[`CSD_B_OPTEN] ? r.opt_res : r.current_limit_pin;
		if (!f.sys_ok)
		begin
			n.eff = min7(`CSD_I_SOFT, r.current_limit_pin);
		end
		else if (r.ctrl[`CSD_B_PINEN])
		begin
			n.eff = min7(f.current_limit_pin_pin, lim_src);
		end
		else
		begin
			n.eff = lim_src;
		end
		n.bsw = r.chg;
		n.pfm = r.conv && (!f.bat_min_ok || !r.chg);
		// ****************************************
		// Boost qualification
		// ****************************************
		if (f.bat_bst_ok && f.vbus_low && f.boost_req && r.bst[`CSD_B_CFG] && f.ts_ok)
		begin
			if (r.bcnt < BST_CYC)
			begin
				n.bcnt = r.bcnt + 32'h0000_0001;
			end
			else
			begin
				n.bst_on = 1'b1;
			end
		end
		else
		begin
			n.bcnt = 32'h0000_0000;
			n.bst_on = 1'b0;
		end
		// ****************************************
		// Register writes; a host write wins over a self-clear
		// ****************************************
		if (wr_in)
		begin
			case (addr_in)
				`CSD_A_CTRL: n.ctrl = wdata_in;
				`CSD_A_CURRENT_LIMIT_PIN: n.current_limit_pin = wdata_in[6:0];
				`CSD_A_VLIM:
				begin
					if (r.ctrl[`CSD_B_ABS])
					begin
						n.vlim = wdata_in;
					end
				end
				`CSD_A_BST:
				begin
					n.bst = wdata_in;
					if (r.bst[`CSD_B_CFG])
					begin
						n.bst[`CSD_B_FREQ] = r.bst[`CSD_B_FREQ];
					end
				end
				`CSD_A_CHG: n.chg = wdata_in[0];
				default: ;
			endcase
		end
		if (rd_in)
		begin
			case (addr_in)
				`CSD_A_CTRL: n.rd = r.ctrl;
				`CSD_A_CURRENT_LIMIT_PIN: n.rd = {1'b0, r.current_limit_pin};
				`CSD_A_VLIM: n.rd = r.vlim;
				`CSD_A_BST: n.rd = r.bst;
				`CSD_A_CHG: n.rd = {7'h00, r.chg};
				`CSD_A_STAT: n.rd = {r.bsw, r.pfm, r.bst_on, r.conv, r.std_stat,
					r.bst_on ? csd_pkg::SRC_BOOST : r.src};
				`CSD_A_OPT: n.rd = {1'b0, r.opt_res};
				`CSD_A_EFF: n.rd = {1'b0, r.eff};
				default: n.rd = 8'h00;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			r <= '0;
			r.ctrl <= `CSD_CTRL_RST;
			r.current_limit_pin <= `CSD_CURRENT_LIMIT_PIN_RST;
			r.vlim <= `CSD_VLIM_RST;
			r.bst <= `CSD_BST_RST;
			r.chg <= 1'b1;
			r.src <= csd_pkg::SRC_NONE;
			r.opt_res <= `CSD_I_SOFT;
			r.eff <= `CSD_I_SOFT;
			r.st <= csd_pkg::S_IDLE;
		end
		else
		begin
			r <= n;
		end
	end

	assign rd_data_out = r.rd;
	assign int_out = r.intp;
	assign conv_en_out = r.conv;
	assign battery_switch_out = r.bsw;
	assign buck_pfm_out = r.pfm;
	assign eff_limit_out = r.eff;
	assign vlimit_out = r.vlim;
	assign lines_out = r.lines;
	assign boost_en_out = r.bst_on;
	assign select_a_out = r.bst[`CSD_B_FREQ];
	assign boost_pfm_dis_out = r.bst[`CSD_B_BPFM];
	assign boost_volt_out = r.bst[`CSD_BV_HI:`CSD_BV_LO];

	// ****************************************
	// Checks
	// ****************************************
	vset_int_a: assert property ((r.st == csd_pkg::S_VSET && r.filt.attach) |=> r.intp)
		else $error("no interrupt after threshold set");
	force_clear_a: assert property ((r.st == csd_pkg::S_VSET && !$past(wr_in)) |-> !r.ctrl[`CSD_B_FDET])
		else $error("force detect bit not cleared");
	vlim_ro_a: assert property ((wr_in && addr_in == `CSD_A_VLIM && !r.ctrl[`CSD_B_ABS]
		&& r.st != csd_pkg::S_VSET) |=> $stable(r.vlim))
		else $error("threshold written while algorithm owns it");
	vlim_rw_a: assert property ((wr_in && addr_in == `CSD_A_VLIM && r.ctrl[`CSD_B_ABS])
		|=> r.vlim == $past(wdata_in))
		else $error("absolute threshold write lost");
	soft_start_a: assert property (!r.filt.sys_ok |=> r.eff <= `CSD_I_SOFT)
		else $error("soft start limit exceeded");
	conv_start_a: assert property ($rose(r.conv) |-> $past(r.st) == csd_pkg::S_VSET)
		else $error("converter started before limit set");
	boost_wait_a: assert property ($rose(r.bst_on) |-> r.bcnt == BST_CYC)
		else $error("boost started without delay");
	freq_lock_a: assert property ((wr_in && addr_in == `CSD_A_BST && r.bst[`CSD_B_CFG])
		|=> r.bst[`CSD_B_FREQ] == $past(r.bst[`CSD_B_FREQ]))
		else $error("boost frequency changed while configured");
	hv12_lines_a: assert property ((r.st == csd_pkg::S_HV && r.ctrl[`CSD_B_HVA])
		|-> r.lines.dp_sink && r.lines.dm_src)
		else $error("wrong line drive for 12 V request");
	hv_off_a: assert property ((r.st == csd_pkg::S_CLS && !r.ctrl[`CSD_B_HVA] && !r.ctrl[`CSD_B_HVB])
		|=> r.st != csd_pkg::S_HV)
		else $error("handshake ran while disabled");
endmodule

/* File: testbench/csd_port_model.sv */
// Model of the USB port or charging adapter on the data lines
`timescale 1ns/100ps
module csd_port_model (
	input  wire logic                clk_in,
	input  wire logic [3:0]          kind_in,
	input  wire csd_pkg::csd_pins_t  base_in,
	input  wire csd_pkg::csd_lines_t lines_in,
	output csd_pkg::csd_pins_t       pins_out
);
	// Kinds: 0 detached, 1 std, 2 charging, 3 dedicated, 4..7 dividers, 8 unknown
	logic [3:0] age_r;

	always_ff @(posedge clk_in)
	begin
		if (kind_in == 4'h0)
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
	end

	always_comb
	begin
		pins_out = base_in;
		pins_out.attach = (kind_in != 4'h0);
		pins_out.vbus_low = (kind_in == 4'h0);
		// Late contact makes the plug look slow; dividers never make contact
		pins_out.contact = (kind_in inside {4'h1, 4'h2, 4'h3, 4'h8}) && (age_r > 4'h5);
		pins_out.port = (kind_in < 4'h4) ? csd_pkg::csd_port_t'(kind_in[1:0]) : csd_pkg::PORT_NONE;
		pins_out.dp_win = (kind_in == 4'h5) ? csd_pkg::WIN_1P2 : (kind_in == 4'h6) ? csd_pkg::WIN_2P0 :
			(kind_in == 4'h4 || kind_in == 4'h7) ? csd_pkg::WIN_2P7 : csd_pkg::WIN_NONE;
		pins_out.dm_win = (kind_in == 4'h4) ? csd_pkg::WIN_2P0 : (kind_in == 4'h5) ? csd_pkg::WIN_1P2 :
			(kind_in == 4'h6 || kind_in == 4'h7) ? csd_pkg::WIN_2P7 : csd_pkg::WIN_NONE;
		// Adapter raises its output only on a valid line pattern
		pins_out.vbus_meas = (kind_in == 4'h0) ? 8'h00 : (lines_in.dp_sink && lines_in.dm_src) ? 8'h78 :
			(lines_in.dp_src && lines_in.dm_sink) ? 8'h5A : 8'h32;
	end
endmodule

/* File: testbench/csd_ctrl_tb.sv */
// Self-checking bench for the source detect and boost control block
`timescale 1ns/100ps
`include "csd_defs.svh"
module csd_ctrl_tb;
	localparam logic [7:0] current_limit_pin_tab [8] = '{8'h0A, 8'h1E, 8'h41, 8'h2A, 8'h28, 8'h14, 8'h30, 8'h0A};
	localparam logic [7:0] code_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h06, 8'h06, 8'h06, 8'h05};
	logic                clk_in = 1'b0;
	logic                rst_in = 1'b1;
	logic [7:0]          addr = 8'h00;
	logic [7:0]          wdata = 8'h00;
	logic                wr = 1'b0;
	logic                rd = 1'b0;
	logic [3:0]          kind = 4'h0;
	csd_pkg::csd_pins_t  base;
	csd_pkg::csd_pins_t  pins;
	csd_pkg::csd_lines_t lines;
	logic [7:0]          rd_data;
	logic [7:0]          vlim;
	logic [7:0]          v;
	logic [6:0]          eff;
	logic [3:0]          bvolt;
	logic                intp, conv, bsw, bpfm, ben, bfreq, bpdis;
	int                  fail_count = 0;
	int                  n_compared = 0;
	int                  i;

	csd_ctrl #(.DCD_CYC(20), .BST_CYC(10), .HV_CYC(10), .OPT_CYC(4)) csd_ctrl_i (
		.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.pins_in(pins), .rd_data_out(rd_data), .int_out(intp), .conv_en_out(conv),
		.battery_switch_out(bsw), .buck_pfm_out(bpfm), .eff_limit_out(eff), .vlimit_out(vlim),
		.lines_out(lines), .boost_en_out(ben), .select_a_out(bfreq), .boost_pfm_dis_out(bpdis),
		.boost_volt_out(bvolt));
	csd_port_model csd_port_model_i (.clk_in(clk_in), .kind_in(kind), .base_in(base), .lines_in(lines),
		.pins_out(pins));

	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bchk(input logic b, input logic e);
		chk({7'h00, b}, {7'h00, e});
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, e);
	endtask
	task automatic wait_int();
		int n;
		n = 0;
		while (intp !== 1'b1 && n < 200)
		begin
			@(posedge clk_in);
			#1 n++;
		end
		bchk(intp, 1'b1);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	// Detach, plug the given kind, then check result, interrupts and line pattern
	task automatic detect(input logic [3:0] k, input logic [7:0] il, input logic [7:0] code, input logic [3:0] lx);
		int n;
		@(posedge clk_in);
		kind <= 4'h0;
		repeat (12) @(posedge clk_in);
		kind <= k;
		n = 0;
		if (lx != 4'h0)
		begin
			while (lines === 4'h0 && n < 200)
			begin
				@(posedge clk_in);
				#1 n++;
			end
			chk({4'h0, lines}, {4'h0, lx});
		end
		wait_int();
		// Detection and threshold pulses fall in adjacent cycles
		@(posedge clk_in);
		#1 bchk(intp, 1'b1);
		bchk(conv, 1'b1);
		@(posedge clk_in);
		#1 bchk(intp, 1'b0);
		rchk(`CSD_A_CURRENT_LIMIT_PIN, il);
		rd_reg(`CSD_A_STAT, v);
		chk(v & 8'h07, code);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and test sequence
	// ****************************************
	initial
	begin
		forever #2 clk_in = ~clk_in;
	end

	initial
	begin
		#80000;
		fail_count++;
		print_verdict();
	end

	initial
	begin
		base = '0;
		base.sys_ok = 1'b1;
		base.bat_min_ok = 1'b1;
		base.bat_bst_ok = 1'b1;
		base.boost_req = 1'b1;
		base.ts_ok = 1'b1;
		base.current_limit_pin_pin = 7'h10;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rchk(`CSD_A_CTRL, 8'hA1);
		rchk(`CSD_A_CURRENT_LIMIT_PIN, 8'h0A);
		rchk(`CSD_A_VLIM, 8'h24);
		rchk(`CSD_A_BST, 8'h30);
		rchk(`CSD_A_CHG, 8'h01);
		rchk(8'h08, 8'h00);
		done("reset values");
		for (i = 0; i < 8; i++)
			detect(4'(i + 1), current_limit_pin_tab[i], code_tab[i], 4'h0);
		done("source table");
		wr_reg(`CSD_A_VLIM, 8'h55);
		rchk(`CSD_A_VLIM, 8'h2C);
		wr_reg(`CSD_A_CTRL, 8'hB1);
		wr_reg(`CSD_A_VLIM, 8'h55);
		rchk(`CSD_A_VLIM, 8'h55);
		chk(vlim, 8'h55);
		done("voltage limit");
		wr_reg(`CSD_A_CTRL, 8'hA3);
		detect(4'h3, 8'h1E, 8'h04, 4'b0110);
		rchk(`CSD_A_VLIM, 8'h72);
		wr_reg(`CSD_A_CTRL, 8'hA5);
		detect(4'h3, 8'h1E, 8'h04, 4'b1001);
		rchk(`CSD_A_VLIM, 8'h54);
		done("handshake");
		wr_reg(`CSD_A_CTRL, 8'hA9);
		wait_int();
		rchk(`CSD_A_CTRL, 8'hA1);
		rchk(`CSD_A_CURRENT_LIMIT_PIN, 8'h41);
		wr_reg(`CSD_A_CTRL, 8'hA0);
		kind <= 4'h0;
		repeat (12) @(posedge clk_in);
		kind <= 4'h2;
		wait_int();
		rchk(`CSD_A_CURRENT_LIMIT_PIN, 8'h41);
		rd_reg(`CSD_A_STAT, v);
		chk(v & 8'h07, 8'h03);
		done("force and bypass");
		wr_reg(`CSD_A_CTRL, 8'h81);
		wr_reg(`CSD_A_CURRENT_LIMIT_PIN, 8'h30);
		repeat (8) @(posedge clk_in);
		chk({1'b0, eff}, 8'h10);
		wr_reg(`CSD_A_CTRL, 8'h01);
		repeat (8) @(posedge clk_in);
		chk({1'b0, eff}, 8'h30);
		base.sys_ok <= 1'b0;
		repeat (8) @(posedge clk_in);
		chk({1'b0, eff}, 8'h04);
		wr_reg(`CSD_A_CHG, 8'h00);
		repeat (4) @(posedge clk_in);
		bchk(bsw, 1'b0);
		bchk(bpfm, 1'b1);
		done("current limit");
		wr_reg(`CSD_A_CTRL, 8'h61);
		repeat (200) @(posedge clk_in);
		rchk(`CSD_A_OPT, 8'h30);
		rchk(`CSD_A_CTRL, 8'h21);
		done("optimizer");
		@(posedge clk_in);
		kind <= 4'h0;
		base.sys_ok <= 1'b1;
		repeat (8) @(posedge clk_in);
		wr_reg(`CSD_A_BST, 8'h31);
		repeat (6) @(posedge clk_in);
		bchk(ben, 1'b0);
		i = 0;
		while (ben !== 1'b1 && i < 40)
		begin
			@(posedge clk_in);
			#1 i++;
		end
		bchk(ben, 1'b1);
		rd_reg(`CSD_A_STAT, v);
		chk(v & 8'h07, 8'h07);
		wr_reg(`CSD_A_BST, 8'h37);
		rchk(`CSD_A_BST, 8'h35);
		bchk(bfreq, 1'b0);
		bchk(bpdis, 1'b1);
		chk({4'h0, bvolt}, 8'h06);
		@(posedge clk_in);
		base.ts_ok <= 1'b0;
		repeat (6) @(posedge clk_in);
		bchk(ben, 1'b0);
		done("boost");
		print_verdict();
	end
endmodule
